// ==== rtl/ewd_pkg.sv ====
`default_nettype none
package ewd_pkg;
  // reference clock period
  localparam int unsigned CLK_NS = 10;
  // glitch rejection window and least accepted pulse on the filtered pins
  localparam int unsigned GLITCH_NS = 100;
  localparam int unsigned PULSE_NS = 1000;
  // a level must hold one cycle longer than the longest glitch to be taken
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FILT_CYC = GLITCH_CYC + 1;
  localparam int unsigned FILT_W = 8;
  // least time the alarm stays low once asserted
  localparam int unsigned MIN_LOW_NS = 20000;
  localparam int unsigned MIN_LOW_CYC = (MIN_LOW_NS + CLK_NS - 1) / CLK_NS;
  // default timeout period and alarm active time
  localparam int unsigned TIMEOUT_US = 3400;
  localparam int unsigned ACTIVE_US = 27200;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_NS;
  localparam int unsigned ACTIVE_CYC = ACTIVE_US * 1000 / CLK_NS;
  localparam int unsigned CNT_W = 32;
  // reset levels of the filtered pins (inhibit defaults low = enabled)
  localparam logic KICK_RST = 1'h0;
  localparam logic INH_RST = 1'h0;
  // which kick edges clear the count
  typedef enum logic {EWD_EDGE_RISE, EWD_EDGE_BOTH} ewd_edge_type;
  // main sequencer states
  typedef enum logic [1:0] {EWD_PWRWAIT, EWD_IDLE, EWD_WATCH, EWD_ALARM} ewd_state_type;
endpackage
`default_nettype wire

// ==== rtl/ewd_sig_if.sv ====
`default_nettype none
interface ewd_sig_if;
  logic kickRise; // one-cycle pulse, filtered kick went high
  logic kickFall; // one-cycle pulse, filtered kick went low
  logic inhLevel; // filtered inhibit level, high disables
  modport src (output kickRise, output kickFall, output inhLevel);
  modport dst (input kickRise, input kickFall, input inhLevel);
endinterface
`default_nettype wire

// ==== rtl/ewd_glitch_filter.sv ====
`default_nettype none
module ewd_glitch_filter #(
  parameter logic RST_LEVEL = 1'h0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw pin and filtered level
  input wire logic rawIn,
  output logic level
);
  typedef struct packed {
    logic s1; // first sync stage, read only by s2
    logic s2; // second sync stage
    logic lvl; // accepted level
    logic [ewd_pkg::FILT_W-1:0] cnt; // cycles the new level has held
  } ewd_filt_type;

  ewd_filt_type q, d;

  // a new level is taken only after it outlasts the glitch window
  always_comb
  begin
    d = q;
    d.s1 = rawIn;
    d.s2 = q.s1;
    if (q.s2 == q.lvl)
    begin
      d.cnt = '0;
    end
    else if (q.cnt == ewd_pkg::FILT_W'(ewd_pkg::FILT_CYC - 1))
    begin
      d.lvl = q.s2;
      d.cnt = '0;
    end
    else
    begin
      d.cnt = q.cnt + ewd_pkg::FILT_W'(1);
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '{s1: RST_LEVEL, s2: RST_LEVEL, lvl: RST_LEVEL, cnt: '0};
    else
      q <= d;
  end

  assign level = q.lvl;
endmodule // ewd_glitch_filter
`default_nettype wire

// ==== rtl/ewd_edge_detect.sv ====
`default_nettype none
module ewd_edge_detect (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filtered levels
  input wire logic kickLevel,
  input wire logic inhLevel,
  // edges toward the sequencer
  ewd_sig_if.src sig
);
  typedef struct packed {
    logic kickPrev; // kick level one cycle ago
    logic rise;
    logic fall;
    logic inh;
  } ewd_edge_state_type;

  ewd_edge_state_type q, d;

  // registered edge pulses, one cycle each
  always_comb
  begin
    d = q;
    d.kickPrev = kickLevel;
    d.rise = kickLevel & ~q.kickPrev;
    d.fall = ~kickLevel & q.kickPrev;
    d.inh = inhLevel;
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '{kickPrev: ewd_pkg::KICK_RST, rise: 1'h0, fall: 1'h0, inh: ewd_pkg::INH_RST};
    else
      q <= d;
  end

  assign sig.kickRise = q.rise;
  assign sig.kickFall = q.fall;
  assign sig.inhLevel = q.inh;
endmodule // ewd_edge_detect
`default_nettype wire

// ==== rtl/ewd_watchdog.sv ====
`default_nettype none
// How it works
// - timeout count starts once supply is good
// - kick edges never start timing, only clear
// - single-edge: only rising kick clears count
// - dual-edge: both kick edges clear count
// - single-edge: alarm low one timeout, restart
// - single-edge: alarm and watch repeat until rise
// - dual-edge: alarm low active time, then restart
// - dual-edge: pulses repeat until any kick edge
// - single-edge: rise ends alarm after 20us
// - dual-edge: kicks ignored during alarm
// - inhibit high clears timing, disables watchdog
// - inhibit low restarts count from zero
// - alarm held 20us even if inhibited
// - kick glitches under 100ns are rejected
// - inhibit glitches under 100ns are rejected
// - inhibit forces alarm high after minimum
module ewd_watchdog #(
  parameter ewd_pkg::ewd_edge_type EDGE_MODE = ewd_pkg::EWD_EDGE_RISE,
  parameter int unsigned TIMEOUT_CYC = ewd_pkg::TIMEOUT_CYC,
  parameter int unsigned ACTIVE_CYC = ewd_pkg::ACTIVE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // supply-good indication, asynchronous
  input wire logic powerGood,
  // host pins, asynchronous
  input wire logic kickInput,
  input wire logic inhibitInput,
  // open-drain alarm pin
  input wire logic alarmOutLowIn,
  output logic alarmOutLowOut,
  output logic alarmOutLowOeN
);
  localparam int unsigned W = ewd_pkg::CNT_W;
  // last count of each interval
  localparam logic [W-1:0] TO_LAST = W'(TIMEOUT_CYC - 1);
  localparam logic [W-1:0] ACT_LAST = W'(ACTIVE_CYC - 1);
  localparam logic [W-1:0] MIN_LAST = W'(ewd_pkg::MIN_LOW_CYC - 1);
  localparam logic SINGLE = (EDGE_MODE == ewd_pkg::EWD_EDGE_RISE);
  // single-edge alarm lasts a timeout period, dual-edge an active time
  localparam logic [W-1:0] ALARM_LAST = SINGLE ? TO_LAST : ACT_LAST;

  typedef struct packed {
    ewd_pkg::ewd_state_type st; // sequencer state
    logic [W-1:0] cnt; // cycles in the current interval
    logic pendKick; // rising kick seen before the minimum low time
    logic pendInh; // inhibit seen during the alarm
    logic pg1; // first sync stage of powerGood
    logic pg2; // synced powerGood
    logic oeN; // low while the alarm pin is pulled down
  } ewd_core_type;

  ewd_core_type q, d;
  logic kickLevel; // filtered kick
  logic inhFilt; // filtered inhibit
  logic validKick; // edge that clears the count in this variant
  logic minDone; // alarm has been low long enough
  logic wantEnd; // a kick or inhibit asks the alarm to end
  ewd_sig_if sig ();

  // pins pass two flops and a glitch window before any use
  ewd_glitch_filter #(.RST_LEVEL(ewd_pkg::KICK_RST)) uKickFilt (
    .mclk(mclk),
    .rst(rst),
    .rawIn(kickInput),
    .level(kickLevel)
  );
  ewd_glitch_filter #(.RST_LEVEL(ewd_pkg::INH_RST)) uInhFilt (
    .mclk(mclk),
    .rst(rst),
    .rawIn(inhibitInput),
    .level(inhFilt)
  );
  ewd_edge_detect uEdge (
    .mclk(mclk),
    .rst(rst),
    .kickLevel(kickLevel),
    .inhLevel(inhFilt),
    .sig(sig.src)
  );

  // falling edges count only in the dual-edge variant
  assign validKick = sig.kickRise | (~SINGLE & sig.kickFall);
  assign minDone = (q.cnt >= MIN_LAST);
  // dual-edge ignores kicks while low, single-edge keeps a rise
  assign wantEnd = q.pendInh | sig.inhLevel | q.pendKick
    | (SINGLE & sig.kickRise);

  // sequencer next state
  always_comb
  begin
    d = q;
    d.pg1 = powerGood;
    d.pg2 = q.pg1;
    case (q.st)
      // hold off until the supply is good, kicks play no part here
      ewd_pkg::EWD_PWRWAIT:
      begin
        d.cnt = '0;
        if (q.pg2)
          d.st = sig.inhLevel ? ewd_pkg::EWD_IDLE : ewd_pkg::EWD_WATCH;
      end
      // disabled: no timing, alarm released
      ewd_pkg::EWD_IDLE:
      begin
        d.cnt = '0;
        if (!sig.inhLevel)
          d.st = ewd_pkg::EWD_WATCH;
      end
      // counting toward a timeout
      ewd_pkg::EWD_WATCH:
      begin
        if (sig.inhLevel)
        begin
          d.st = ewd_pkg::EWD_IDLE;
          d.cnt = '0;
        end
        else if (validKick)
        begin
          d.cnt = '0;
        end
        else if (q.cnt == TO_LAST)
        begin
          d.st = ewd_pkg::EWD_ALARM;
          d.cnt = '0;
          d.oeN = 1'h0;
        end
        else
        begin
          d.cnt = q.cnt + W'(1);
        end
      end
      // alarm pulled low
      ewd_pkg::EWD_ALARM:
      begin
        d.cnt = q.cnt + W'(1);
        if (sig.inhLevel)
          d.pendInh = 1'h1;
        if (SINGLE && sig.kickRise)
          d.pendKick = 1'h1;
        // end at the natural length, or early once the minimum has passed
        if (q.cnt == ALARM_LAST || (minDone && wantEnd))
        begin
          // watching restarts unless inhibited, so pulses repeat
          d.st = sig.inhLevel ? ewd_pkg::EWD_IDLE : ewd_pkg::EWD_WATCH;
          d.cnt = '0;
          d.pendKick = 1'h0;
          d.pendInh = 1'h0;
          d.oeN = 1'h1;
        end
      end
      default:
      begin
        d.st = ewd_pkg::EWD_PWRWAIT;
        d.cnt = '0;
        d.oeN = 1'h1;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      q <= '{st: ewd_pkg::EWD_PWRWAIT, cnt: '0, pendKick: 1'h0, pendInh: 1'h0,
        pg1: 1'h0, pg2: 1'h0, oeN: 1'h1};
    else
      q <= d;
  end

  // open-drain: only ever drives low, the pull-up makes the high
  assign alarmOutLowOut = 1'h0;
  assign alarmOutLowOeN = q.oeN;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_NO_START:
    assert property (q.st == ewd_pkg::EWD_PWRWAIT && !q.pg2 |=> q.st == ewd_pkg::EWD_PWRWAIT)
    else $error("timing started before supply good");
  AST_PWR_START:
    assert property (q.st == ewd_pkg::EWD_PWRWAIT && q.pg2 && !sig.inhLevel
      |=> q.st == ewd_pkg::EWD_WATCH && q.cnt == '0)
    else $error("timing did not start on supply good");
  AST_KICK_CLEARS:
    assert property (q.st == ewd_pkg::EWD_WATCH && !sig.inhLevel && validKick
      |=> q.cnt == '0 && q.oeN)
    else $error("valid kick did not clear count");
  AST_FALL_IGNORED:
    assert property (SINGLE && q.st == ewd_pkg::EWD_WATCH && sig.kickFall && !sig.inhLevel
      && q.cnt < TO_LAST |=> q.cnt == $past(q.cnt) + W'(1))
    else $error("falling kick acted in single-edge mode");
  AST_TIMEOUT:
    assert property (q.st == ewd_pkg::EWD_WATCH && q.cnt == TO_LAST && !validKick
      && !sig.inhLevel |=> !alarmOutLowOeN && q.cnt == '0)
    else $error("no alarm at timeout");
  AST_MIN_LOW:
    assert property ($rose(alarmOutLowOeN) |-> $past(q.cnt) >= MIN_LAST)
    else $error("alarm shorter than minimum");
  AST_FULL_LENGTH:
    assert property ($rose(alarmOutLowOeN) && !$past(q.pendInh) && !$past(sig.inhLevel)
      && !$past(q.pendKick) && !(SINGLE && $past(sig.kickRise)) |-> $past(q.cnt) == ALARM_LAST)
    else $error("alarm length wrong");
  AST_INH_DISABLES:
    assert property (q.st == ewd_pkg::EWD_WATCH && sig.inhLevel
      |=> q.st == ewd_pkg::EWD_IDLE ##1 alarmOutLowOeN)
    else $error("inhibit did not disable");
  AST_INH_RELEASE:
    assert property (q.st == ewd_pkg::EWD_ALARM && minDone && (q.pendInh || sig.inhLevel)
      |=> alarmOutLowOeN)
    else $error("alarm held after inhibit and minimum");
  AST_RESTART:
    assert property (q.st == ewd_pkg::EWD_IDLE && !sig.inhLevel
      |=> q.st == ewd_pkg::EWD_WATCH && q.cnt == '0)
    else $error("count did not restart from zero");
  AST_DUAL_IGNORE:
    assert property (!SINGLE && q.st == ewd_pkg::EWD_ALARM && !minDone && validKick
      |=> !alarmOutLowOeN)
    else $error("kick shortened dual-edge alarm");

  // pin level follows the sequencer state, so a stuck enable shows at once
  AST_PWR_HIGH:
    assert property (q.st == ewd_pkg::EWD_PWRWAIT |-> alarmOutLowOeN)
    else $error("alarm asserted before timing started");

  AST_IDLE_HIGH:
    assert property (q.st == ewd_pkg::EWD_IDLE |-> alarmOutLowOeN)
    else $error("alarm asserted while disabled");

  AST_WATCH_HIGH:
    assert property (q.st == ewd_pkg::EWD_WATCH |-> alarmOutLowOeN)
    else $error("alarm asserted while watching");

  AST_ALARM_LOW:
    assert property (q.st == ewd_pkg::EWD_ALARM |-> !alarmOutLowOeN)
    else $error("alarm released inside the alarm state");

  // counters never run past their last count, which would hang the sequencer
  AST_IDLE_CLEAR:
    assert property (q.st == ewd_pkg::EWD_IDLE |-> q.cnt == '0)
    else $error("timing not cleared while disabled");

  AST_WATCH_BOUND:
    assert property (q.st == ewd_pkg::EWD_WATCH |-> q.cnt <= TO_LAST)
    else $error("watch count overran the timeout");

  AST_ALARM_BOUND:
    assert property (q.st == ewd_pkg::EWD_ALARM |-> q.cnt <= ALARM_LAST)
    else $error("alarm count overran its length");

  // every release of the alarm clears the count to zero, restarting timing unless inhibited
  AST_ALARM_END:
    assert property ($rose(alarmOutLowOeN) |-> q.st != ewd_pkg::EWD_ALARM && q.cnt == '0)
    else $error("alarm release did not restart timing");

  AST_INH_NO_ALARM:
    assert property (sig.inhLevel && q.st != ewd_pkg::EWD_ALARM |=> alarmOutLowOeN)
    else $error("alarm raised while inhibited");

  // pending requests live only inside an alarm
  AST_PEND_CLEAR:
    assert property (q.st != ewd_pkg::EWD_ALARM |-> !q.pendKick && !q.pendInh)
    else $error("stale pending request outside the alarm");

  AST_DUAL_NO_PEND:
    assert property (!SINGLE |-> !q.pendKick)
    else $error("dual-edge variant remembered a kick");

  // a falling kick must not shorten the single-edge alarm
  AST_SINGLE_FALL_ALARM:
    assert property (SINGLE && q.st == ewd_pkg::EWD_ALARM && sig.kickFall && !sig.inhLevel
      && !q.pendInh && !q.pendKick && q.cnt < ALARM_LAST |=> !alarmOutLowOeN)
    else $error("falling kick ended single-edge alarm");

  AST_SINGLE_KICK_END:
    assert property (SINGLE && q.st == ewd_pkg::EWD_ALARM && minDone && sig.kickRise
      |=> alarmOutLowOeN)
    else $error("rising kick did not end alarm after minimum");


  COV_TIMEOUT: cover property (q.st == ewd_pkg::EWD_WATCH ##1 q.st == ewd_pkg::EWD_ALARM);
  COV_KICK_END: cover property (q.st == ewd_pkg::EWD_ALARM && q.pendKick ##1 alarmOutLowOeN);
  COV_INH_END: cover property (q.st == ewd_pkg::EWD_ALARM ##1 q.st == ewd_pkg::EWD_IDLE);
  COV_PIN_LOW: cover property (!alarmOutLowIn && !alarmOutLowOeN);
  COV_REPEAT: cover property ($rose(alarmOutLowOeN) ##1 q.st == ewd_pkg::EWD_WATCH);
endmodule // ewd_watchdog
`default_nettype wire

// ==== tb/ewd_host_model.sv ====
`default_nettype none
module ewd_host_model (
  // clock
  input wire logic mclk,
  // host pins toward both watchdogs
  output var logic kickInput,
  output var logic inhibitInput,
  // open-drain alarm pins of the two variants
  input wire logic oeNRise,
  input wire logic outRise,
  input wire logic oeNBoth,
  input wire logic outBoth,
  output logic wireRise,
  output logic wireBoth
);
  timeunit 1ns;
  timeprecision 1ps;
  // the pull-up wins whenever the driver lets go
  assign wireRise = oeNRise ? 1'h1 : outRise;
  assign wireBoth = oeNBoth ? 1'h1 : outBoth;
  // pins are never left floating, not even at time zero
  initial
  begin
    kickInput = 1'h0;
    inhibitInput = 1'h0;
  end
  // both pins change together just after a rising edge
  task automatic drive(input logic k, input logic i);
    @(posedge mclk);
    kickInput <= k;
    inhibitInput <= i;
  endtask
endmodule // ewd_host_model
`default_nettype wire

// ==== tb/edge_kicked_watchdog_timer_tb.sv ====
`default_nettype none
module edge_kicked_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened counts, both kept above the minimum low time
  localparam int TO = 3000;
  localparam int ACT = 2500;
  localparam int MINLOW = ewd_pkg::MIN_LOW_CYC;
  // clock, reset and supply
  logic mclk;
  logic rst;
  logic powerGood;
  // host pins and alarm pins
  logic kickInput;
  logic inhibitInput;
  logic oeNRise;
  logic outRise;
  logic oeNBoth;
  logic outBoth;
  logic wireRise;
  logic wireBoth;
  // bookkeeping
  int failures;
  int totalChecks;
  int elapsed;
  // single-edge variant
  ewd_watchdog #(.EDGE_MODE(ewd_pkg::EWD_EDGE_RISE), .TIMEOUT_CYC(TO), .ACTIVE_CYC(ACT)) dut_u (
    .mclk(mclk), .rst(rst), .powerGood(powerGood), .kickInput(kickInput),
    .inhibitInput(inhibitInput), .alarmOutLowIn(wireRise), .alarmOutLowOut(outRise),
    .alarmOutLowOeN(oeNRise));
  // dual-edge variant on the same host pins
  ewd_watchdog #(.EDGE_MODE(ewd_pkg::EWD_EDGE_BOTH), .TIMEOUT_CYC(TO), .ACTIVE_CYC(ACT)) dutBoth (
    .mclk(mclk), .rst(rst), .powerGood(powerGood), .kickInput(kickInput),
    .inhibitInput(inhibitInput), .alarmOutLowIn(wireBoth), .alarmOutLowOut(outBoth),
    .alarmOutLowOeN(oeNBoth));
  // host side
  ewd_host_model host_u (
    .mclk(mclk), .kickInput(kickInput), .inhibitInput(inhibitInput), .oeNRise(oeNRise),
    .outRise(outRise), .oeNBoth(oeNBoth), .outBoth(outBoth), .wireRise(wireRise),
    .wireBoth(wireBoth));
  // 100 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // report totals and end the run
  task automatic stop_test();
    $display("checks %0d failures %0d", totalChecks, failures);
    if ((failures == 0) && (totalChecks > 0))
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare with a small tolerance; unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
    totalChecks++;
    if (((seen + tol >= exp) && (seen <= exp + tol)) !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t saw %0d expected %0d", $time, seen, exp);
    end
  endtask
  // step edges, sampling after the design has settled
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      elapsed++;
    end
  endtask
  // change the host pins; this uses up one edge
  task automatic set(input logic k, input logic i);
    host_u.drive(k, i);
    #1;
    elapsed++;
  endtask
  // wait for a wire level under a bound, then judge when it came
  task automatic mark(input bit both, input logic lvl, input int exp, input int tol);
    int n;
    n = 0;
    while (((both ? wireBoth : wireRise) !== lvl) && (n < 40000))
    begin
      tick(1);
      n++;
    end
    if (n >= 40000)
    begin
      failures++;
      $display("[FAIL] %0t alarm pin never settled", $time);
      stop_test();
    end
    check(elapsed, exp, tol);
  endtask
  // inhibit long enough to outlast any minimum low time, then restart both
  task automatic resync();
    set(kickInput, 1'h1);
    tick(2200);
    set(kickInput, 1'h0);
    elapsed = 0;
  endtask
  // kicks in power-wait do nothing; timing starts from supply good
  task automatic s_power();
    set(1'h1, 1'h0);
    tick(50);
    set(1'h0, 1'h0);
    tick(50);
    @(posedge mclk);
    powerGood <= 1'h1;
    #1;
    elapsed = 0;
    mark(1'b0, 1'h0, TO + 3, 3);
    mark(1'b1, 1'h0, TO + 3, 3);
  endtask
  // unkicked alarms repeat with their own lengths
  task automatic s_repeat();
    elapsed = 0;
    mark(1'b1, 1'h1, ACT, 1);
    mark(1'b0, 1'h1, TO, 1);
    mark(1'b1, 1'h0, ACT + TO + 1, 1);
    mark(1'b0, 1'h0, 2 * TO + 1, 1);
  endtask
  // a falling kick clears only the dual-edge count
  task automatic s_kick();
    resync();
    tick(1000);
    set(1'h1, 1'h0);
    tick(1000);
    set(1'h0, 1'h0);
    elapsed = 0;
    mark(1'b0, 1'h0, TO + 14 - 1000, 5);
    mark(1'b1, 1'h0, TO + 14, 5);
  endtask
  // a rise during the alarm: early end after the minimum, or ignored
  task automatic s_alarm_kick();
    resync();
    mark(1'b0, 1'h0, TO + 15, 5);
    elapsed = 0;
    mark(1'b1, 1'h0, 0, 1);
    tick(99);
    set(1'h1, 1'h0);
    mark(1'b0, 1'h1, MINLOW, 1);
    mark(1'b1, 1'h1, ACT, 1);
    mark(1'b0, 1'h0, MINLOW + TO + 1, 1);
    mark(1'b1, 1'h0, ACT + TO + 1, 1);
  endtask
  // inhibit during the alarm, hold disabled, then restart from zero
  task automatic s_inhibit();
    int lows;
    resync();
    mark(1'b0, 1'h0, TO + 15, 5);
    elapsed = 0;
    tick(99);
    set(kickInput, 1'h1);
    mark(1'b0, 1'h1, MINLOW, 1);
    mark(1'b1, 1'h1, MINLOW, 1);
    lows = 0;
    repeat (4000)
    begin
      tick(1);
      if ((wireRise !== 1'h1) || (wireBoth !== 1'h1))
        lows++;
    end
    check(lows, 0, 0);
    set(kickInput, 1'h0);
    elapsed = 0;
    mark(1'b0, 1'h0, TO + 15, 5);
  endtask
  // 80 ns pulses on either pin leave the count running
  task automatic s_glitch();
    resync();
    tick(999);
    set(~kickInput, 1'h0);
    tick(7);
    set(~kickInput, 1'h0);
    tick(500);
    set(kickInput, 1'h1);
    tick(7);
    set(kickInput, 1'h0);
    mark(1'b0, 1'h0, TO + 15, 5);
    mark(1'b1, 1'h0, TO + 15, 5);
  endtask
  // main sequence
  initial
  begin
    rst = 1'h1;
    powerGood = 1'h0;
    elapsed = 0;
    failures = 0;
    totalChecks = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    s_power();
    s_repeat();
    s_kick();
    s_alarm_kick();
    s_inhibit();
    s_glitch();
    stop_test();
  end
endmodule // edge_kicked_watchdog_timer_tb
`default_nettype wire
